// *** core/ssf_cond_detect.sv ***
`timescale 1ns/1ps
`default_nettype none

module ssf_cond_detect
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_start,
   output logic o_stop
);
   import ssf_pkg::*;

   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic scl_reg;
   logic sda_reg;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // three stages; only the second and third are compared
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
         sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
      end
   end

   // filtered levels move only when stages two and three agree
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end
      else
      begin
         if (scl_sync_reg[1] == scl_sync_reg[2])
            scl_reg <= scl_sync_reg[2];
         if (sda_sync_reg[1] == sda_sync_reg[2])
            sda_reg <= sda_sync_reg[2];
      end
   end

   // ----------------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------------
   // data edge while clock high; scl is compared at its settled level
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_start <= 1'b0;
         o_stop <= 1'b0;
      end
      else
      begin
         o_start <= scl_reg && sda_reg && (sda_sync_reg[1] == sda_sync_reg[2])
            && !sda_sync_reg[2];
         o_stop <= scl_reg && !sda_reg && (sda_sync_reg[1] == sda_sync_reg[2])
            && sda_sync_reg[2];
      end
   end

endmodule

`default_nettype wire

// *** core/ssf_pkg.sv ***
package ssf_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] SSF_BUF_OFFSET = 8'h13;
   localparam logic [7:0] SSF_CTRL_OFFSET = 8'h14;
   localparam logic [7:0] SSF_STAT_OFFSET = 8'h94;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SSF_CTRL_WRITE_COLLISION_FLAG = 7;
   localparam int SSF_CTRL_OVF = 6;
   localparam int SSF_CTRL_EN = 5;
   localparam int SSF_CTRL_CKP = 4;
   localparam int SSF_STAT_SMP = 7;
   localparam int SSF_STAT_CKE = 6;
   localparam int SSF_STAT_DA = 5;
   localparam int SSF_STAT_STOP = 4;
   localparam int SSF_STAT_START = 3;
   localparam int SSF_STAT_RW = 2;
   localparam int SSF_STAT_UA = 1;
   localparam int SSF_STAT_BF = 0;

   // ----------------------------------------------------------------
   // reset values and mode codes
   // ----------------------------------------------------------------
   localparam logic [7:0] SSF_CTRL_RESET = 8'h00;
   localparam logic [7:0] SSF_STAT_RESET = 8'h00;
   localparam logic [7:0] SSF_BUF_RESET = 8'h00;
   localparam logic [3:0] SSF_MODE_I2C_7 = 4'h6;
   localparam logic [3:0] SSF_MODE_I2C_10 = 4'h7;
   localparam logic [3:0] SSF_MODE_I2C_7_SP = 4'hB;
   localparam logic [3:0] SSF_MODE_I2C_10_SP = 4'hF;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ssf_req_t;

   // byte events reported by the shift engine
   typedef struct packed {
      logic rx_done;
      logic [7:0] rx_data;
      logic tx_done;
      logic is_data;
      logic addr_match;
      logic rw_bit;
      logic addr_update;
      logic busy;
   } ssf_shift_t;

endpackage

// *** core/ssf_status_flags.sv ***
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RQ1] in i2c mode data/address flag shows whether the last byte was data
// [RQ2] stop flag set by the latest stop condition, zero after reset
// [RQ3] stop flag clears on port disable or a later start
// [RQ4] start flag clears on port disable or a later stop
// [RQ5] read/write bit captured at each matching address in i2c mode
// [RQ6] buffer-full set when a received byte completes, clear when empty
// [RQ7] write collision set when the buffer is written while shifting
// [RQ8] software clears write collision; writable control bits reset to zero
// [RQ9] i2c receive overflow set when a byte arrives into a full buffer
// [RQ10] i2c transmit holds buffer-full high until the transmission completes
module ssf_status_flags
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire ssf_pkg::ssf_req_t i_req,
   output logic [7:0] o_rdata,
   input wire ssf_pkg::ssf_shift_t i_shift,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic [7:0] o_tx_data,
   output logic o_tx_load,
   output logic o_port_enable,
   output logic o_clk_release,
   output logic [3:0] o_mode,
   output logic o_sample_late,
   output logic o_clk_edge
);
   import ssf_pkg::*;

   logic [7:0] ctrl_reg;
   logic [7:0] buf_reg;
   logic smp_reg;
   logic cke_reg;
   logic da_reg;
   logic stop_reg;
   logic start_reg;
   logic rw_reg;
   logic ua_reg;
   logic bf_reg;
   logic tx_bf_reg;
   logic start_det;
   logic stop_det;
   logic i2c_mode;
   logic enabled;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_buf;
   logic rd_buf;
   logic collide;
   logic overflow;
   logic [7:0] stat_view;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // the four mode codes that select i2c slave operation
   function automatic logic is_i2c(input logic [3:0] mode);
      case (mode)
         SSF_MODE_I2C_7, SSF_MODE_I2C_10,
         SSF_MODE_I2C_7_SP, SSF_MODE_I2C_10_SP: is_i2c = 1'b1;
         default: is_i2c = 1'b0;
      endcase
   endfunction

   // bus condition detector on the raw pins
   ssf_cond_detect u_cond
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_start(start_det),
      .o_stop(stop_det)
   );

   // address decode, strobes from the register port
   assign i2c_mode = is_i2c(ctrl_reg[3:0]);
   assign enabled = ctrl_reg[SSF_CTRL_EN];
   assign wr_ctrl = i_req.wr && (i_req.addr == SSF_CTRL_OFFSET);
   assign wr_stat = i_req.wr && (i_req.addr == SSF_STAT_OFFSET);
   assign wr_buf = i_req.wr && (i_req.addr == SSF_BUF_OFFSET);
   assign rd_buf = i_req.rd && (i_req.addr == SSF_BUF_OFFSET);

   // [RQ7] collision on busy write
   assign collide = wr_buf && i_shift.busy;
   // [RQ9] overflow into full buffer
   assign overflow = enabled && i_shift.rx_done && bf_reg;

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   // [RQ8] software clears collision
   // hardware set wins over a same-cycle software clear
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         ctrl_reg <= SSF_CTRL_RESET;
      else
      begin
         if (wr_ctrl)
            ctrl_reg <= i_req.wdata;
         if (collide)
            ctrl_reg[SSF_CTRL_WRITE_COLLISION_FLAG] <= 1'b1;
         // overflow only counted in i2c mode or spi slave modes
         if (overflow && (i2c_mode || ctrl_reg[2]))
            ctrl_reg[SSF_CTRL_OVF] <= 1'b1;
      end
   end

   // sampling options held in the status register's upper bits
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         smp_reg <= 1'b0;
         cke_reg <= 1'b0;
      end
      else if (wr_stat)
      begin
         smp_reg <= i_req.wdata[SSF_STAT_SMP];
         cke_reg <= i_req.wdata[SSF_STAT_CKE];
      end
   end

   // ----------------------------------------------------------------
   // bus condition flags
   // ----------------------------------------------------------------
   // disable wipes both; a condition clears the other one
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         stop_reg <= 1'b0;
         start_reg <= 1'b0;
      end
      else if (!enabled)
      begin
         // [RQ3] disable clears stop
         stop_reg <= 1'b0;
         // [RQ4] disable clears start
         start_reg <= 1'b0;
      end
      else if (i2c_mode)
      begin
         if (stop_det)
         begin
            // [RQ2] stop sets flag
            stop_reg <= 1'b1;
            // [RQ4] stop clears start
            start_reg <= 1'b0;
         end
         else if (start_det)
         begin
            start_reg <= 1'b1;
            // [RQ3] start clears stop
            stop_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // byte bookkeeping
   // ----------------------------------------------------------------
   // [RQ1] data versus address
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         da_reg <= 1'b0;
      else if (!enabled)
         da_reg <= 1'b0;
      else if (i2c_mode && (i_shift.rx_done || i_shift.tx_done))
         da_reg <= i_shift.is_data;
   end

   // [RQ5] direction capture
   // stays until the next match or a port disable; only meaningful up to the stop
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         rw_reg <= 1'b0;
      else if (!enabled)
         rw_reg <= 1'b0;
      else if (i2c_mode && i_shift.addr_match)
         rw_reg <= i_shift.rw_bit;
   end

   // address update request mirrors the engine while enabled in i2c mode
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         ua_reg <= 1'b0;
      else
         ua_reg <= enabled && i2c_mode && i_shift.addr_update;
   end

   // ----------------------------------------------------------------
   // data buffer and buffer-full
   // ----------------------------------------------------------------
   // a byte arriving into a full buffer is dropped, not merged
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         buf_reg <= SSF_BUF_RESET;
      else if (enabled && i_shift.rx_done && !bf_reg)
         buf_reg <= i_shift.rx_data;
      else if (wr_buf && !i_shift.busy)
         buf_reg <= i_req.wdata;
   end

   // [RQ6] receive fills, read empties
   // a read in the same cycle as a new byte leaves the flag set
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         bf_reg <= 1'b0;
      else if (!enabled)
         bf_reg <= 1'b0;
      else if (i_shift.rx_done)
         bf_reg <= 1'b1;
      else if (rd_buf)
         bf_reg <= 1'b0;
   end

   // [RQ10] transmit in progress
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         tx_bf_reg <= 1'b0;
      else if (!enabled || !i2c_mode)
         tx_bf_reg <= 1'b0;
      else if (wr_buf && !i_shift.busy)
         tx_bf_reg <= 1'b1;
      else if (i_shift.tx_done)
         tx_bf_reg <= 1'b0;
   end

   // transmit hand-off to the shift engine; collided writes never load
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_tx_data <= SSF_BUF_RESET;
         o_tx_load <= 1'b0;
      end
      else
      begin
         o_tx_load <= wr_buf && !i_shift.busy && enabled;
         if (wr_buf && !i_shift.busy)
            o_tx_data <= i_req.wdata;
      end
   end

   // ----------------------------------------------------------------
   // read path and configuration outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      stat_view = SSF_STAT_RESET;
      stat_view[SSF_STAT_SMP] = smp_reg;
      stat_view[SSF_STAT_CKE] = cke_reg;
      stat_view[SSF_STAT_DA] = da_reg;
      stat_view[SSF_STAT_STOP] = stop_reg;
      stat_view[SSF_STAT_START] = start_reg;
      stat_view[SSF_STAT_RW] = rw_reg;
      stat_view[SSF_STAT_UA] = ua_reg;
      stat_view[SSF_STAT_BF] = bf_reg || tx_bf_reg;
   end

   // data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (i_req.rd)
      begin
         case (i_req.addr)
            SSF_BUF_OFFSET: o_rdata <= buf_reg;
            SSF_CTRL_OFFSET: o_rdata <= ctrl_reg;
            SSF_STAT_OFFSET: o_rdata <= stat_view;
            default: o_rdata <= 8'h00;
         endcase
      end
      else
         o_rdata <= 8'h00;
   end

   // configuration copies, registered so outputs come from flops
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_port_enable <= 1'b0;
         o_clk_release <= 1'b0;
         o_mode <= 4'h0;
         o_sample_late <= 1'b0;
         o_clk_edge <= 1'b0;
      end
      else
      begin
         o_port_enable <= ctrl_reg[SSF_CTRL_EN];
         o_clk_release <= ctrl_reg[SSF_CTRL_CKP];
         o_mode <= ctrl_reg[3:0];
         o_sample_late <= smp_reg;
         o_clk_edge <= cke_reg;
      end
   end

endmodule

`default_nettype wire

// *** testbench/ssf_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssf_bus_model
(
   input wire logic i_clk,
   output var ssf_pkg::ssf_shift_t o_shift,
   output var logic o_scl,
   output var logic o_sda
);
   import ssf_pkg::*;
   // ---------------------------------------------------------------
   // bus master and shift engine stand-in
   // ---------------------------------------------------------------
   // lines idle high, as the pull-ups leave them
   initial
   begin
      o_shift = '0;
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // n bytes back to back; data scrambled once released
   task automatic byte_in(input logic dat, input logic [7:0] v, input int n);
      o_shift.rx_done <= 1'b1;
      o_shift.is_data <= dat;
      o_shift.rx_data <= v;
      tick(n);
      o_shift.rx_done <= 1'b0;
      o_shift.rx_data <= ~v;
   endtask
   task automatic tx_end();
      o_shift.tx_done <= 1'b1;
      o_shift.is_data <= 1'b1;
      tick(1);
      o_shift.tx_done <= 1'b0;
   endtask
   task automatic match(input logic rw);
      o_shift.addr_match <= 1'b1;
      o_shift.rw_bit <= rw;
      tick(1);
      o_shift.addr_match <= 1'b0;
      o_shift.rw_bit <= ~rw;
   endtask
   task automatic busy(input logic b);
      o_shift.busy <= b;
   endtask
   // start: data falls under high clock; stop: data rises under it
   task automatic cond(input logic stop);
      o_sda <= ~stop;
      tick(8);
      o_scl <= 1'b1;
      tick(8);
      o_sda <= stop;
      tick(8);
      o_scl <= stop;
      tick(8);
   endtask
endmodule
`default_nettype wire

// *** testbench/ssf_status_flags_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssf_status_flags_chk
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire ssf_pkg::ssf_req_t i_req,
   input wire logic [7:0] o_rdata,
   input wire ssf_pkg::ssf_shift_t i_shift,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_load,
   input wire logic o_port_enable,
   input wire logic [3:0] o_mode
);
   import ssf_pkg::*;
   logic rd_st;
   logic rd_ct;
   logic wr_bf;
   logic on;
   logic rx;
   // ---------------------------------------------------------------
   // request decode
   // ---------------------------------------------------------------
   // short names keep each property to a few lines
   assign rd_st = i_req.rd && i_req.addr == SSF_STAT_OFFSET;
   assign rd_ct = i_req.rd && i_req.addr == SSF_CTRL_OFFSET;
   assign wr_bf = i_req.wr && i_req.addr == SSF_BUF_OFFSET;
   assign on = o_port_enable && o_mode == SSF_MODE_I2C_7;
   assign rx = i_shift.rx_done && on;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   // full after byte
   a_full_rx:
   assert property ((rx ##1 rd_st) |=> o_rdata[SSF_STAT_BF])
   else $error("full flag not set");
   a_kind_rx:
   assert property ((rx ##1 (rd_st && !i_shift.tx_done))
      |=> o_rdata[SSF_STAT_DA] == $past(i_shift.is_data, 2))
   else $error("data flag wrong");
   a_dir_capture:
   assert property (((i_shift.addr_match && on) ##1
      (rd_st && !i_shift.addr_match))
      |=> o_rdata[SSF_STAT_RW] == $past(i_shift.rw_bit, 2))
   else $error("direction wrong");
   a_overflow_set:
   assert property ((rx ##1 (rx && !(i_req.rd && i_req.addr ==
      SSF_BUF_OFFSET)) ##1 rd_ct) |=> o_rdata[SSF_CTRL_OVF])
   else $error("overflow not set");
   a_collision_set:
   assert property (((wr_bf && i_shift.busy && o_port_enable) ##1 rd_ct)
      |=> o_rdata[SSF_CTRL_WRITE_COLLISION_FLAG])
   else $error("collision not set");
   a_load_idle:
   assert property (wr_bf && !i_shift.busy && o_port_enable
      |=> o_tx_load && o_tx_data == $past(i_req.wdata))
   else $error("byte not loaded");
   a_full_tx:
   assert property (((wr_bf && !i_shift.busy && on) ##1
      (rd_st && !i_shift.tx_done)) |=> o_rdata[SSF_STAT_BF])
   else $error("full flag not held");
   a_off_clears:
   assert property (rd_st && !o_port_enable && !$past(o_port_enable)
      |=> o_rdata[5:2] == 4'h0 && !o_rdata[SSF_STAT_BF])
   else $error("flags kept while off");
   c_start: cover property (rd_st ##1 o_rdata[SSF_STAT_START]);
   c_load: cover property (o_tx_load);
   c_coll: cover property (wr_bf && i_shift.busy);
endmodule
bind ssf_status_flags ssf_status_flags_chk ssf_status_flags_chk_i (
   .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .o_rdata(o_rdata),
   .i_shift(i_shift), .o_tx_data(o_tx_data), .o_tx_load(o_tx_load),
   .o_port_enable(o_port_enable), .o_mode(o_mode));
`default_nettype wire

// *** testbench/test_ssf_status_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_ssf_status_flags;
   import ssf_pkg::*;
   localparam logic [7:0] B = SSF_BUF_OFFSET;
   localparam logic [7:0] C = SSF_CTRL_OFFSET;
   localparam logic [7:0] S = SSF_STAT_OFFSET;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   ssf_req_t req = '0;
   ssf_shift_t shift;
   logic scl;
   logic sda;
   logic [7:0] rdata;
   logic [7:0] d;
   logic [7:0] tx_data;
   logic tx_load;
   logic pen;
   logic crel;
   logic [3:0] mode;
   logic smp;
   logic cke;
   logic [7:0] seen_tx = 8'h00;
   int n_load = 0;
   int n_mismatch = 0;
   int compares = 0;
   always #2 i_clk = ~i_clk;
   ssf_status_flags ssf_status_flags_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata),
      .i_shift(shift), .i_scl(scl), .i_sda(sda), .o_tx_data(tx_data),
      .o_tx_load(tx_load), .o_port_enable(pen), .o_clk_release(crel),
      .o_mode(mode), .o_sample_late(smp), .o_clk_edge(cke));
   ssf_bus_model ssf_bus_model_i (
      .i_clk(i_clk), .o_shift(shift), .o_scl(scl), .o_sda(sda));
   // the load pulse lasts one cycle, so keep the last byte and a count
   always @(posedge i_clk)
   begin
      if (tx_load)
      begin
         seen_tx <= tx_data;
         n_load <= n_load + 1;
      end
   end
   // ---------------------------------------------------------------
   // bus cycles and checks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      req.addr <= a;
      req.wdata <= v;
      req.wr <= 1'b1;
      @(posedge i_clk);
      req.wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge i_clk);
      req.rd <= 1'b0;
      #1 v = rdata;
      @(posedge i_clk);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd(C, d);
      chk(d, SSF_CTRL_RESET);
      rd(S, d);
      chk(d, SSF_STAT_RESET);
      chk({2'b00, pen, crel, mode}, SSF_CTRL_RESET);
      chk({6'h00, smp, cke}, 8'h00);
      // only the two sampling bits of status take a write
      wr(S, 8'hFF);
      rd(S, d);
      chk(d, 8'hC0);
      chk({6'h00, smp, cke}, 8'h03);
      wr(8'h55, 8'hFF);
      rd(8'h55, d);
      chk(d, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_rx();
      wr(C, 8'h26);
      ssf_bus_model_i.byte_in(1'b1, 8'hA5, 1);
      rd(S, d);
      chk(d & 8'h21, 8'h21);
      rd(B, d);
      chk(d, 8'hA5);
      rd(S, d);
      chk(d & 8'h01, 8'h00);
      ssf_bus_model_i.byte_in(1'b0, 8'h5A, 1);
      rd(S, d);
      chk(d & 8'h21, 8'h01);
      ssf_bus_model_i.byte_in(1'b1, 8'hC3, 2);
      rd(C, d);
      chk(d, 8'h66);
      rd(B, d);
      chk(d, 8'h5A);
      wr(C, 8'h26);
      rd(C, d);
      chk(d, 8'h26);
      $display("t_rx done");
   endtask
   task automatic t_rw();
      ssf_bus_model_i.match(1'b1);
      rd(S, d);
      chk(d & 8'h04, 8'h04);
      ssf_bus_model_i.match(1'b0);
      rd(S, d);
      chk(d & 8'h04, 8'h00);
      $display("t_rw done");
   endtask
   task automatic t_tx();
      wr(B, 8'h3C);
      rd(S, d);
      chk(d & 8'h01, 8'h01);
      chk(seen_tx, 8'h3C);
      ssf_bus_model_i.tx_end();
      rd(S, d);
      chk(d & 8'h21, 8'h20);
      ssf_bus_model_i.busy(1'b1);
      wr(B, 8'h77);
      rd(C, d);
      chk(d, 8'hA6);
      chk(n_load[7:0], 8'h01);
      chk(seen_tx, 8'h3C);
      ssf_bus_model_i.tick(20);
      rd(C, d);
      chk(d, 8'hA6);
      ssf_bus_model_i.busy(1'b0);
      wr(C, 8'h26);
      rd(C, d);
      chk(d, 8'h26);
      chk({2'b00, pen, crel, mode}, 8'h26);
      $display("t_tx done");
   endtask
   // start, stop, start; then the port is switched off
   task automatic t_pins();
      for (int k = 0; k < 3; k++)
      begin
         ssf_bus_model_i.cond(k[0]);
         rd(S, d);
         chk(d & 8'h18, k[0] ? 8'h10 : 8'h08);
      end
      wr(C, 8'h16);
      ssf_bus_model_i.tick(2);
      rd(S, d);
      chk(d & 8'h3D, 8'h00);
      chk({2'b00, pen, crel, mode}, 8'h16);
      $display("t_pins done");
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      t_reset();
      t_rx();
      t_rw();
      t_tx();
      t_pins();
      wrap_up();
   end
   // a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
